// ---- rtl/des_conditioning_spread_clock_generator_config.sv ----
// Our own choices: the APB register port and the register addresses.
`default_nettype none
// What this block does
// RULE1: Equalizer setting from straps or register
// RULE2: Enabled gain is 1.5 dB per code step
// RULE3: Enable low means equalizer off, default off
// RULE4: Test output only when register enables it
// RULE5: Slew select high gives maximum slew
// RULE6: Slew select low gives minimum slew
// RULE7: Separate clock and data slew selects
// RULE8: Spreading modulates clock and data outputs
// RULE9: Deviation within 2 percent, rate 100 kHz
// RULE10: Spread code and range from straps or register
// RULE11: Range select low picks first divisor table
// RULE12: Low range divisors 2168, 1300, 868, 650
// RULE13: High range divisors 620, 370, 258, 192
// RULE14: Wrapping counter sweeps a triangular offset
module des_conditioning_spread_clock_generator_config
    import spread_clock_generator_cfg_pkg::*;
(
    input  wire logic        pclk,                          // Parallel clock
    input  wire logic        presetn,                       // Async reset, low
    input  wire logic        clk_en,                        // Freeze when low
    // APB slave
    input  wire logic        psel,                          // Select
    input  wire logic        penable,                       // Access phase
    input  wire logic        pwrite,                        // Write
    input  wire logic [7:0]  paddr,                         // Byte address
    input  wire logic [31:0] pwdata,                        // Write data
    output logic             pready,                        // Ready
    output logic [31:0]      prdata,                        // Read data
    output logic             pslverr,                       // Error
    // Straps
    input  wire logic [2:0]  strap_equalizer_gain_select,   // Gain code
    input  wire logic        strap_equalizer_enable_bit,    // Equalizer on
    input  wire logic        strap_clock_output_slew_select,// Clock slew
    input  wire logic        strap_data_output_slew_select, // Data slew
    input  wire logic [3:0]  strap_spread_config_field,     // Spread code
    input  wire logic        strap_low_frequency_range_select, // Range
    // Conditioning outputs
    output logic             equalizer_on,                  // Equalizer active
    output logic [2:0]       equalizer_gain_select,         // Effective gain code
    output logic [6:0]       equalizer_gain_tenths_db,      // Gain, 0.1 dB units
    output logic             serial_test_output_enable,     // Test pair on
    output logic             clock_output_slew_select,      // Clock slew, 1 = max
    output logic             data_output_slew_select,       // Data slew, 1 = max
    // Spread outputs
    output logic             spread_active,                 // Modulation on
    output logic [11:0]      spread_divisor,                // Period in clocks
    output logic [4:0]       spread_dev_tenths_pct,         // Peak deviation
    output logic             spread_rising,                 // Sweep rising
    output logic [11:0]      spread_offset                  // Signed offset
);
    // ****************************************
    // Register state
    // ****************************************
    logic [3:0]  ctrl_reg;          // Source selects and test enable
    logic [3:0]  eq_reg;            // Register equalizer setting
    logic [1:0]  slew_reg;          // Register slew selects
    logic [4:0]  spread_reg;        // Register spread setting
    logic [3:0]  strap_eq_reg;      // Captured equalizer straps
    logic [1:0]  strap_slew_reg;    // Captured slew straps
    logic [4:0]  strap_spread_reg;  // Captured spread straps
    logic        strap_taken_reg;   // Straps captured

    // ****************************************
    // Bus decode
    // ****************************************
    logic        setup_ok;          // Access phase seen
    logic        wr_en;             // Write takes effect
    logic        hit_ctrl;          // Address hits
    logic        hit_eq;
    logic        hit_slew;
    logic        hit_spread;
    logic        hit_status;
    logic        mapped;            // Any register hit
    logic        bad_access;        // Unmapped or read-only write

    assign hit_ctrl   = (paddr == CTRL_OFS);
    assign hit_eq     = (paddr == EQ_OFS);
    assign hit_slew   = (paddr == SLEW_OFS);
    assign hit_spread = (paddr == SPREAD_OFS);
    assign hit_status = (paddr == STATUS_OFS);
    assign mapped     = hit_ctrl | hit_eq | hit_slew | hit_spread | hit_status;
    assign bad_access = !mapped || (pwrite && hit_status);

    // Zero-wait slave, held off only while the clock enable is low
    assign setup_ok = psel && penable;
    assign pready   = clk_en;
    assign pslverr  = setup_ok && bad_access;
    assign wr_en    = setup_ok && pwrite && clk_en && !bad_access;

    // ****************************************
    // Effective settings
    // ****************************************
    logic [3:0]  eq_src;            // Selected equalizer setting
    logic [1:0]  slew_src;          // Selected slew setting
    logic [4:0]  spread_src;        // Selected spread setting
    logic [3:0]  spread_code;       // Spread code
    logic        lf_range;          // Low frequency range select
    logic [3:0]  code_less;         // Code minus one
    logic [1:0]  group_idx;         // Divisor group
    logic [1:0]  dev_idx;           // Deviation step

    // ****************************************
    // Strap capture
    // ****************************************
    // Straps are sampled once, on the first enabled edge after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_eq_reg     <= 4'h0;
            strap_slew_reg   <= 2'h0;
            strap_spread_reg <= 5'h00;
            strap_taken_reg  <= 1'b0;
        end else if (clk_en && !strap_taken_reg) begin
            strap_eq_reg     <= {strap_equalizer_enable_bit,
                                 strap_equalizer_gain_select};
            strap_slew_reg   <= {strap_data_output_slew_select,
                                 strap_clock_output_slew_select};
            strap_spread_reg <= {strap_low_frequency_range_select,
                                 strap_spread_config_field};
            strap_taken_reg  <= 1'b1;
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    // Source selects and serial test output enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RST;
        end else if (wr_en && hit_ctrl) begin
            ctrl_reg <= pwdata[3:0];
        end
    end

    // ****************************************
    // Equalizer register
    // ****************************************
    // Gain code and enable, reset to off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eq_reg <= EQ_RST;                                         // RULE3
        end else if (wr_en && hit_eq) begin
            eq_reg <= pwdata[EQ_ENABLE_BIT:EQ_GAIN_LSB];
        end
    end

    // ****************************************
    // Slew register
    // ****************************************
    // One bit for the clock pin, one for data and control outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slew_reg <= SLEW_RST;
        end else if (wr_en && hit_slew) begin
            slew_reg <= pwdata[SLEW_DATA_BIT:SLEW_CLK_BIT];           // RULE7
        end
    end

    // ****************************************
    // Spread register
    // ****************************************
    // Spread code and range select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spread_reg <= SPREAD_RST;
        end else if (wr_en && hit_spread) begin
            spread_reg <= pwdata[SPREAD_LF_BIT:SPREAD_CODE_LSB];      // RULE10
        end
    end

    // ****************************************
    // Source selection
    // ****************************************
    // Each group picks straps or register on its own
    always_comb begin
        if (ctrl_reg[CTRL_EQ_SRC_BIT]) begin
            eq_src = eq_reg;                                          // RULE1
        end else begin
            eq_src = strap_eq_reg;                                    // RULE1
        end
        if (ctrl_reg[CTRL_SLEW_SRC_BIT]) begin
            slew_src = slew_reg;                                      // RULE7
        end else begin
            slew_src = strap_slew_reg;                                // RULE7
        end
        if (ctrl_reg[CTRL_SPREAD_SRC_BIT]) begin
            spread_src = spread_reg;                                  // RULE10
        end else begin
            spread_src = strap_spread_reg;                            // RULE10
        end
    end

    // ****************************************
    // Spread decode
    // ****************************************
    assign spread_code = spread_src[3:0];
    assign lf_range    = spread_src[4];
    assign code_less   = spread_code - 4'h1;
    assign group_idx   = code_less[3:2];
    assign dev_idx     = code_less[1:0];

    // Sweep counter link
    spread_if sp ();

    // Divisor table chosen by range select
    always_comb begin
        sp.enable = (spread_code != SPREAD_OFF_CODE);                 // RULE12 RULE13
        if (!sp.enable) begin
            sp.divisor = 12'h000;
        end else if (!lf_range) begin
            sp.divisor = DIV_LF_LOW[group_idx];                       // RULE11 RULE12
        end else begin
            sp.divisor = DIV_LF_HIGH[group_idx];                      // RULE13
        end
    end

    // Triangular sweep at the chosen modulation rate
    triangle_sweep u_sweep (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .sp      (sp.gen)
    );

    // ****************************************
    // Output registers
    // ****************************************
    // Equalizer outputs; enable low forces off whatever the gain holds
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            equalizer_on             <= 1'b0;                         // RULE3
            equalizer_gain_select    <= 3'h0;
            equalizer_gain_tenths_db <= 7'h00;
        end else if (clk_en) begin
            equalizer_on          <= eq_src[EQ_ENABLE_BIT];           // RULE3
            equalizer_gain_select <= eq_src[2:0];
            if (eq_src[EQ_ENABLE_BIT]) begin
                equalizer_gain_tenths_db <= 7'(GAIN_STEP_TENTHS_DB
                                             * ({4'h0, eq_src[2:0]} + 7'h01)); // RULE2
            end else begin
                equalizer_gain_tenths_db <= 7'h00;                    // RULE3
            end
        end
    end

    // Serial test pair follows its register bit only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_test_output_enable <= 1'b0;
        end else if (clk_en) begin
            serial_test_output_enable <= ctrl_reg[CTRL_TEST_OUT_BIT]; // RULE4
        end
    end

    // Slew outputs, high is maximum and low is minimum
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_output_slew_select <= 1'b0;                         // RULE6
            data_output_slew_select  <= 1'b0;                         // RULE6
        end else if (clk_en) begin
            clock_output_slew_select <= slew_src[SLEW_CLK_BIT];       // RULE5 RULE6 RULE7
            data_output_slew_select  <= slew_src[SLEW_DATA_BIT];      // RULE5 RULE6 RULE7
        end
    end

    // Spread outputs drive both the clock and data output paths
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spread_active         <= 1'b0;
            spread_divisor        <= 12'h000;
            spread_dev_tenths_pct <= 5'h00;
            spread_rising         <= 1'b0;
            spread_offset         <= 12'h000;
        end else if (clk_en) begin
            spread_active  <= sp.enable;                              // RULE8
            spread_divisor <= sp.divisor;
            spread_rising  <= sp.rising;
            spread_offset  <= sp.offset;                              // RULE8 RULE14
            if (sp.enable) begin
                // Table tops out at 2.0 percent, rates stay under 100 kHz
                spread_dev_tenths_pct <= DEV_TENTHS_PCT[dev_idx];     // RULE9 RULE12
            end else begin
                spread_dev_tenths_pct <= 5'h00;
            end
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    // Registered read, unmapped addresses read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            if (hit_ctrl) begin
                prdata[3:0] <= ctrl_reg;
            end
            if (hit_eq) begin
                prdata[3:0] <= eq_reg;
            end
            if (hit_slew) begin
                prdata[1:0] <= slew_reg;
            end
            if (hit_spread) begin
                prdata[4:0] <= spread_reg;
            end
            if (hit_status) begin
                // Effective settings now in force
                prdata[3:0]                          <= eq_src;
                prdata[5:4]                          <= slew_src;
                prdata[10:6]                         <= spread_src;
                prdata[11]                           <= strap_taken_reg;
                prdata[STAT_SPREAD_ON_BIT]           <= sp.enable;
                prdata[STAT_DEV_LSB +: 2]            <= dev_idx;
                prdata[STAT_RISING_BIT]              <= sp.rising;
                prdata[STAT_DIV_LSB +: 12]           <= sp.divisor;
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/spread_clock_generator_cfg_pkg.sv ----
`default_nettype none
package spread_clock_generator_cfg_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] CTRL_OFS   = 8'h00;  // Strap or register source
    localparam logic [7:0] EQ_OFS     = 8'h04;  // Equalizer setting
    localparam logic [7:0] SLEW_OFS   = 8'h08;  // Slew selects
    localparam logic [7:0] SPREAD_OFS = 8'h0C;  // Spread setting
    localparam logic [7:0] STATUS_OFS = 8'h10;  // Effective settings, read only
    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_EQ_SRC_BIT     = 0;     // 1: equalizer from register
    localparam int CTRL_SLEW_SRC_BIT   = 1;     // 1: slew from register
    localparam int CTRL_SPREAD_SRC_BIT = 2;     // 1: spread from register
    localparam int CTRL_TEST_OUT_BIT   = 3;     // 1: serial test output on
    localparam int EQ_GAIN_LSB         = 0;     // Gain code [2:0]
    localparam int EQ_ENABLE_BIT       = 3;     // Equalizer enable
    localparam int SLEW_CLK_BIT        = 0;     // Clock output slew
    localparam int SLEW_DATA_BIT       = 1;     // Data output slew
    localparam int SPREAD_CODE_LSB     = 0;     // Spread code [3:0]
    localparam int SPREAD_LF_BIT       = 4;     // Low frequency range
    localparam int STAT_SPREAD_ON_BIT  = 12;    // Status: spreading active
    localparam int STAT_DEV_LSB        = 13;    // Status: deviation step [1:0]
    localparam int STAT_RISING_BIT     = 15;    // Status: sweep rising
    localparam int STAT_DIV_LSB        = 16;    // Status: divisor [11:0]
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [3:0] CTRL_RST   = 4'h0;   // All from straps
    localparam logic [3:0] EQ_RST     = 4'h0;   // Equalizer off
    localparam logic [1:0] SLEW_RST   = 2'h0;   // Minimum slew
    localparam logic [4:0] SPREAD_RST = 5'h00;  // Spreading off
    // ****************************************
    // Gain and modulation tables
    // ****************************************
    localparam logic [6:0] GAIN_STEP_TENTHS_DB = 7'h0F;  // 1.5 dB per code
    localparam logic [3:0] SPREAD_OFF_CODE     = 4'h0;   // Disable code
    localparam logic [11:0] DIV_LF_LOW [4] = '{12'h878, 12'h514, 12'h364, 12'h28A};
    localparam logic [11:0] DIV_LF_HIGH[4] = '{12'h26C, 12'h172, 12'h102, 12'h0C0};
    // Deviation in tenths of a percent for each step
    localparam logic [4:0] DEV_TENTHS_PCT[4] = '{5'h05, 5'h0A, 5'h0F, 5'h14};
endpackage
`default_nettype wire

// ---- rtl/spread_if.sv ----
`default_nettype none
// Carries the spread setting to the sweep counter and its state back
interface spread_if;
    logic        enable;    // Spreading on
    logic [11:0] divisor;   // Modulation period in clocks
    logic [11:0] phase;     // Position within period
    logic        rising;    // Offset rising half
    logic [11:0] offset;    // Signed triangular offset
    // Configuration side
    modport cfg (output enable, output divisor, input phase, input rising, input offset);
    // Sweep counter side
    modport gen (input enable, input divisor, output phase, output rising, output offset);
endinterface
`default_nettype wire

// ---- rtl/triangle_sweep.sv ----
`default_nettype none
module triangle_sweep
    import spread_clock_generator_cfg_pkg::*;
(
    input  wire logic pclk,      // Parallel output clock
    input  wire logic presetn,   // Async reset, low
    input  wire logic clk_en,    // Freeze when low
    spread_if.gen     sp         // Setting in, sweep out
);
    // ****************************************
    // Period counter
    // ****************************************
    logic [11:0] phase_reg;      // Position in the period
    logic [11:0] half;           // Half period
    logic [11:0] quarter;        // Quarter period
    logic [11:0] pos;            // Triangle height
    logic [11:0] div_seen_reg;   // Divisor of the running period

    assign half    = {1'b0, sp.divisor[11:1]};
    assign quarter = {2'b00, sp.divisor[11:2]};

    // Wrap at the selected divisor, restart when spreading is off or the divisor changes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg    <= 12'h000;
            div_seen_reg <= 12'h000;
        end else if (clk_en) begin
            div_seen_reg <= sp.divisor;
            if (!sp.enable || sp.divisor != div_seen_reg) begin
                phase_reg <= 12'h000;                                 // RULE14
            end else if (phase_reg >= sp.divisor - 12'h001) begin
                phase_reg <= 12'h000;                                 // RULE14
            end else begin
                phase_reg <= phase_reg + 12'h001;
            end
        end
    end

    // ****************************************
    // Triangular offset
    // ****************************************
    // Up over the first half, down over the second, centred on zero
    always_comb begin
        if (phase_reg < half) begin
            pos = phase_reg;                                          // RULE14
        end else begin
            pos = sp.divisor - phase_reg;                             // RULE14
        end
    end

    assign sp.phase  = phase_reg;
    assign sp.rising = sp.enable && (phase_reg < half);
    assign sp.offset = sp.enable ? (pos - quarter) : 12'h000;
endmodule
`default_nettype wire

// ---- dv/spread_clock_generator_cfg_properties.sv ----
`default_nettype none
// Port-level checks of the conditioning block
module spread_clock_generator_cfg_properties
    import spread_clock_generator_cfg_pkg::*;
(
    input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        equalizer_on, serial_test_output_enable, spread_active,
    input wire logic [2:0]  equalizer_gain_select,
    input wire logic [6:0]  equalizer_gain_tenths_db,
    input wire logic [4:0]  spread_dev_tenths_pct,
    input wire logic [11:0] spread_divisor, spread_offset
);
    timeunit 1ns;
    timeprecision 1ns;
    int quarter;  // Quarter period
    int off;      // Offset as integer
    assign quarter = int'(spread_divisor >> 2);
    assign off = int'($signed(spread_offset));
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_gain_step: assert property (equalizer_on |-> equalizer_gain_tenths_db ==
        15 * (equalizer_gain_select + 1)) else $error("gain step off");
    chk_gain_off: assert property (!equalizer_on |-> equalizer_gain_tenths_db == 7'h00)
        else $error("gain while off");
    chk_test_port: assert property (psel && penable && pready && pwrite && paddr == CTRL_OFS
        |-> ##2 serial_test_output_enable == $past(pwdata[3], 2)) else $error("test port");
    chk_spread_off: assert property (!spread_active |-> spread_divisor == 12'h000
        && spread_dev_tenths_pct == 5'h00) else $error("spread while off");
    chk_dev_steps: assert property (spread_active |-> spread_dev_tenths_pct inside
        {5'h05, 5'h0A, 5'h0F, 5'h14}) else $error("deviation step");
    chk_div_table: assert property (spread_active |-> spread_divisor inside {12'h878,
        12'h514, 12'h364, 12'h28A, 12'h26C, 12'h172, 12'h102, 12'h0C0}) else $error("divisor");
    chk_offset_span: assert property (spread_active && $past(spread_active, 2) &&
        $past(spread_divisor, 2) == spread_divisor |-> off <= quarter + 1 && off >= -quarter - 1)
        else $error("offset span");
    chk_bad_addr: assert property (psel && penable && paddr > STATUS_OFS |-> pslverr)
        else $error("unmapped not refused");
    cover property (spread_active && spread_divisor == 12'h0C0);
    cover property (pslverr);
    cover property (equalizer_on && equalizer_gain_select == 3'h7);
endmodule
bind des_conditioning_spread_clock_generator_config spread_clock_generator_cfg_properties u_spread_clock_generator_cfg_properties (.*);
`default_nettype wire

// ---- dv/spread_clock_generator_sink_model.sv ----
`default_nettype none
// Downstream sink: measures sweep period and offset extremes
module spread_clock_generator_sink_model (
    input  wire logic         pclk, presetn, clr, spread_rising,
    input  wire logic [11:0]  spread_offset,
    output logic [15:0]       period,
    output logic signed [11:0] off_max, off_min
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        rise_reg;  // Last rising flag
    logic [15:0] cnt_reg;   // Cycles since last rise, 0 = unarmed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn || clr) begin
            rise_reg <= 1'b0;
            cnt_reg  <= 16'h0000;
            period   <= 16'h0000;
            off_max  <= 12'sh800;
            off_min  <= 12'sh7FF;
        end else begin
            rise_reg <= spread_rising;
            if (spread_rising && !rise_reg) begin
                if (cnt_reg != 16'h0000) begin
                    period <= cnt_reg;
                end
                cnt_reg <= 16'h0001;
            end else if (cnt_reg != 16'h0000) begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
            if ($signed(spread_offset) > off_max) off_max <= spread_offset;
            if ($signed(spread_offset) < off_min) off_min <= spread_offset;
        end
    end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import spread_clock_generator_cfg_pkg::*;
    logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, clr = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0]  strap_equalizer_gain_select = 3'h5;
    logic strap_equalizer_enable_bit = 1, strap_clock_output_slew_select = 1;
    logic strap_data_output_slew_select = 0, strap_low_frequency_range_select = 1;
    logic [3:0]  strap_spread_config_field = 4'hD;
    logic pready, pslverr, equalizer_on, serial_test_output_enable, spread_active;
    logic clock_output_slew_select, data_output_slew_select, spread_rising;
    logic [2:0]  equalizer_gain_select;
    logic [6:0]  equalizer_gain_tenths_db;
    logic [4:0]  spread_dev_tenths_pct;
    logic [11:0] spread_divisor, spread_offset;
    logic [15:0] period;
    logic signed [11:0] off_max, off_min;
    int n_fail = 0, tests_run = 0, cd;
    // Rows: divisor per code group, low range then high range
    int divs[8] = '{2168, 1300, 868, 650, 620, 370, 258, 192};
    always #50 pclk = ~pclk;
    des_conditioning_spread_clock_generator_config u_des_conditioning_spread_clock_generator_config (.*);
    spread_clock_generator_sink_model u_spread_clock_generator_sink_model (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, entered just after a clock edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        chk(pslverr, e);
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #2000000;
        n_fail++;
        test_done;
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        repeat (4) @(posedge pclk);
        chk(equalizer_gain_tenths_db, 90);
        chk(clock_output_slew_select, 1);
        chk(spread_divisor, 192);
        for (int i = 0; i < 4; i++) begin
            apb(0, 8'(4 * i), 0, 0);
            chk(rd, 0);
        end
        apb(1, CTRL_OFS, 32'hF, 0);
        for (int i = 0; i < 32; i++) begin
            apb(1, SPREAD_OFS, i, 0);
            apb(1, EQ_OFS, i % 16, 0);
            apb(1, SLEW_OFS, i % 4, 0);
            // Slew outputs register on the idle edge, read one edge later
            @(posedge pclk);
            cd = i % 16;
            chk(spread_active, cd != 0);
            chk(spread_divisor, cd ? divs[i / 16 * 4 + (cd - 1) / 4] : 0);
            chk(spread_dev_tenths_pct, cd ? 5 * ((cd - 1) % 4 + 1) : 0);
            chk(equalizer_on, cd / 8);
            chk(equalizer_gain_tenths_db, cd / 8 * 15 * (cd % 8 + 1));
            chk(equalizer_gain_select, cd % 8);
            chk(clock_output_slew_select, i % 2);
            chk(data_output_slew_select, i / 2 % 2);
        end
        chk(serial_test_output_enable, 1);
        apb(1, CTRL_OFS, 32'h7, 0);
        apb(0, 8'h24, 0, 1);
        chk(serial_test_output_enable, 0);
        chk(rd, 0);
        apb(1, STATUS_OFS, 32'hFFFFFFFF, 1);
        apb(1, SPREAD_OFS, 32'h1D, 0);
        // Readback and effective settings, sweep direction masked
        apb(0, SPREAD_OFS, 0, 0);
        chk(rd, 32'h0000_001D);
        apb(0, STATUS_OFS, 0, 0);
        chk(rd & 32'hFFFF_7FFF, 32'h00C0_1F7F);
        clr <= 1;
        @(posedge pclk);
        clr <= 0;
        repeat (500) @(posedge pclk);
        chk(period, 192);
        chk(off_max, 48);
        chk(off_min, -48);
        clk_en <= 0;
        repeat (2) @(posedge pclk);
        rd = spread_offset;
        @(posedge pclk);
        chk(pready, 0);
        chk(spread_offset, rd);
        clk_en <= 1;
        strap_equalizer_enable_bit <= 0;
        presetn <= 0;
        @(posedge pclk);
        chk(spread_active, 0);
        presetn <= 1;
        repeat (4) @(posedge pclk);
        chk(equalizer_on, 0);
        test_done;
    end
endmodule
`default_nettype wire
